// >>> rtl/boot_clock_strap_pkg.sv
`default_nettype none

package boot_clock_strap_pkg;

    // Boot source strap encodings
    typedef enum logic [1:0] {
        BOOT_SPI_SLAVE  = 2'h0,
        BOOT_SPI_MASTER = 2'h1,
        BOOT_PARALLEL   = 2'h2,
        BOOT_ROM        = 2'h3
    } boot_mode_t;

    // Clock ratio strap encodings
    localparam logic [1:0] CLK_STRAP_32 = 2'h0;
    localparam logic [1:0] CLK_STRAP_16 = 2'h1;
    localparam logic [1:0] CLK_STRAP_6  = 2'h2;
    localparam logic [1:0] CLK_STRAP_RSV = 2'h3;

    localparam int MULT_W = 7;
    localparam logic [MULT_W-1:0] MULT_32  = 7'h20;
    localparam logic [MULT_W-1:0] MULT_16  = 7'h10;
    localparam logic [MULT_W-1:0] MULT_6   = 7'h06;
    localparam logic [MULT_W-1:0] MULT_MIN = 7'h01;
    localparam logic [MULT_W-1:0] MULT_MAX = 7'h40;

    // Divisor select 0..3 means 1,2,4,8
    localparam logic [1:0] DIV_SEL_1 = 2'h0;
    localparam logic [3:0] DIV_ONE   = 4'h1;

    typedef struct packed {
        logic [MULT_W-1:0] mult;
        logic [3:0]        div;
    } clk_ratio_t;

    typedef struct packed {
        logic        spi_slave;
        logic        spi_master;
        logic        parallel8;
        logic        rom_exec;
    } boot_sel_t;

endpackage

`default_nettype wire

// >>> rtl/boot_clock_strap_config.sv
`timescale 1ns/100ps
`default_nettype none

module boot_clock_strap_config (
    input  wire logic                                    clock_in,
    input  wire logic                                    rst_b_in,
    input  wire logic [1:0]                              boot_source_straps_in,
    input  wire logic [1:0]                              clock_ratio_straps_in,
    input  wire logic                                    boot_done_in,
    input  wire logic                                    sw_ratio_write_in,
    input  wire logic [boot_clock_strap_pkg::MULT_W-1:0] sw_mult_in,
    input  wire logic [1:0]                              sw_div_sel_in,
    output logic                                         straps_valid_out,
    output logic [1:0]                                   boot_mode_out,
    output boot_clock_strap_pkg::boot_sel_t              boot_sel_out,
    output logic                                         byte_wide_load_out,
    output boot_clock_strap_pkg::clk_ratio_t             clk_ratio_out,
    output logic                                         sw_ratio_active_out,
    output logic                                         sw_ratio_error_out
);

    function automatic boot_clock_strap_pkg::boot_sel_t decode_boot(input logic [1:0] m);
        boot_clock_strap_pkg::boot_sel_t s;
        s            = '0;
        s.spi_slave  = (m == boot_clock_strap_pkg::BOOT_SPI_SLAVE);
        s.spi_master = (m == boot_clock_strap_pkg::BOOT_SPI_MASTER);
        s.parallel8  = (m == boot_clock_strap_pkg::BOOT_PARALLEL);
        s.rom_exec   = (m == boot_clock_strap_pkg::BOOT_ROM);
        return s;
    endfunction

    function automatic logic [boot_clock_strap_pkg::MULT_W-1:0] strap_mult(input logic [1:0] c);
        logic [boot_clock_strap_pkg::MULT_W-1:0] r;
        case (c)
            boot_clock_strap_pkg::CLK_STRAP_32: r = boot_clock_strap_pkg::MULT_32;
            boot_clock_strap_pkg::CLK_STRAP_16: r = boot_clock_strap_pkg::MULT_16;
            boot_clock_strap_pkg::CLK_STRAP_6:  r = boot_clock_strap_pkg::MULT_6;
            boot_clock_strap_pkg::CLK_STRAP_RSV: r = boot_clock_strap_pkg::MULT_6;
            default:                            r = boot_clock_strap_pkg::MULT_6;
        endcase
        return r;
    endfunction

    // Divisor select code to actual divisor
    function automatic logic [3:0] div_decode(input logic [1:0] sel);
        logic [3:0] d;
        d = 4'(4'h1 << sel);
        return d;
    endfunction

    logic                                      valid_reg,  valid_next;
    boot_clock_strap_pkg::boot_mode_t          mode_reg,   mode_next;
    boot_clock_strap_pkg::boot_sel_t           sel_reg,    sel_next;
    logic                                      byte_reg,   byte_next;
    boot_clock_strap_pkg::clk_ratio_t          ratio_reg,  ratio_next;
    logic                                      sw_reg,     sw_next;
    logic                                      err_reg,    err_next;
    logic                                      sw_ok;

    assign sw_ok = (sw_mult_in >= boot_clock_strap_pkg::MULT_MIN)
                && (sw_mult_in <= boot_clock_strap_pkg::MULT_MAX);

    always_comb begin
        valid_next = valid_reg;
        mode_next  = mode_reg;
        sel_next   = sel_reg;
        byte_next  = byte_reg;
        ratio_next = ratio_reg;
        sw_next    = sw_reg;
        err_next   = 1'b0;
        if (!valid_reg) begin
            valid_next       = 1'b1;
            mode_next        = boot_clock_strap_pkg::boot_mode_t'(boot_source_straps_in);
            sel_next         = decode_boot(boot_source_straps_in);
            byte_next        = (boot_source_straps_in == boot_clock_strap_pkg::BOOT_PARALLEL);
            ratio_next.mult  = strap_mult(clock_ratio_straps_in);
            ratio_next.div   = boot_clock_strap_pkg::DIV_ONE;
        end else if (sw_ratio_write_in) begin
            if (boot_done_in && sw_ok) begin
                ratio_next.mult = sw_mult_in;
                ratio_next.div  = div_decode(sw_div_sel_in);
                sw_next         = 1'b1;
            end else begin
                err_next = 1'b1;
            end
        end
    end

    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            valid_reg <= 1'b0;
            mode_reg  <= boot_clock_strap_pkg::BOOT_SPI_SLAVE;
            sel_reg   <= '0;
            byte_reg  <= 1'b0;
            ratio_reg <= '0;
            sw_reg    <= 1'b0;
            err_reg   <= 1'b0;
        end else begin
            valid_reg <= valid_next;
            mode_reg  <= mode_next;
            sel_reg   <= sel_next;
            byte_reg  <= byte_next;
            ratio_reg <= ratio_next;
            sw_reg    <= sw_next;
            err_reg   <= err_next;
        end
    end

    assign straps_valid_out    = valid_reg;
    assign boot_mode_out       = mode_reg;
    assign boot_sel_out        = sel_reg;
    assign byte_wide_load_out  = byte_reg;
    assign clk_ratio_out       = ratio_reg;
    assign sw_ratio_active_out = sw_reg;
    assign sw_ratio_error_out  = err_reg;

    // Strap capture checks
    a_mode_hold: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        valid_reg && $past(valid_reg) |-> mode_reg == $past(mode_reg))
        else $error("boot mode changed after capture");

    a_sel_hold: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        valid_reg && $past(valid_reg) |-> sel_reg == $past(sel_reg) && byte_reg == $past(byte_reg))
        else $error("boot select changed after capture");

    a_valid_stay: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        $past(valid_reg) |-> valid_reg)
        else $error("strap valid dropped without reset");

    a_mode_map: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        $rose(valid_reg) |-> mode_reg == $past(boot_source_straps_in))
        else $error("boot mode differs from straps at capture");

    a_rom_decode: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        valid_reg |-> sel_reg.rom_exec == (mode_reg == boot_clock_strap_pkg::BOOT_ROM))
        else $error("rom select mismatch");

    a_rom_clean: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        valid_reg && sel_reg.rom_exec |-> !byte_reg && !sel_reg.spi_slave && !sel_reg.spi_master)
        else $error("external load selected with rom start");

    a_onehot_sel: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        valid_reg |-> $onehot(sel_reg))
        else $error("boot select not one-hot");

    a_spi_decode: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        valid_reg |-> sel_reg.spi_slave == (mode_reg == boot_clock_strap_pkg::BOOT_SPI_SLAVE)
            && sel_reg.spi_master == (mode_reg == boot_clock_strap_pkg::BOOT_SPI_MASTER))
        else $error("spi select mismatch");

    a_par_decode: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        valid_reg |-> sel_reg.parallel8 == (mode_reg == boot_clock_strap_pkg::BOOT_PARALLEL))
        else $error("parallel select mismatch");

    a_byte_load: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        valid_reg |-> byte_reg == sel_reg.parallel8)
        else $error("byte load mismatch");

    a_strap_ratio: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        $rose(valid_reg) |-> ratio_reg.div == boot_clock_strap_pkg::DIV_ONE
            && (ratio_reg.mult == boot_clock_strap_pkg::MULT_32 || ratio_reg.mult == boot_clock_strap_pkg::MULT_16
            || ratio_reg.mult == boot_clock_strap_pkg::MULT_6))
        else $error("strap ratio illegal");

    a_ratio_map: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        $rose(valid_reg) |-> ratio_reg.mult == (
            $past(clock_ratio_straps_in) == boot_clock_strap_pkg::CLK_STRAP_32 ? boot_clock_strap_pkg::MULT_32 :
            $past(clock_ratio_straps_in) == boot_clock_strap_pkg::CLK_STRAP_16 ? boot_clock_strap_pkg::MULT_16 :
            boot_clock_strap_pkg::MULT_6))
        else $error("strap ratio not mapped");

    a_strap_clean: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        $rose(valid_reg) |-> !sw_reg && !err_reg)
        else $error("software state set at capture");

    // Software ratio checks
    a_sw_range: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        sw_reg |-> ratio_reg.mult >= boot_clock_strap_pkg::MULT_MIN
            && ratio_reg.mult <= boot_clock_strap_pkg::MULT_MAX
            && $onehot(ratio_reg.div) && ratio_reg.div <= 4'h8)
        else $error("software ratio out of range");

    a_sw_gate: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        valid_reg && sw_ratio_write_in && !boot_done_in |=> ratio_reg == $past(ratio_reg) && err_reg)
        else $error("ratio changed before boot done");

    a_sw_take: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        valid_reg && sw_ratio_write_in && boot_done_in && sw_ok |=> ratio_reg.mult == $past(sw_mult_in) && sw_reg)
        else $error("software ratio not taken");

    a_div_take: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        valid_reg && sw_ratio_write_in && boot_done_in && sw_ok
            |=> ratio_reg.div == 4'(4'h1 << $past(sw_div_sel_in)))
        else $error("software divisor not taken");

    a_range_refuse: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        valid_reg && sw_ratio_write_in && !sw_ok |=> ratio_reg == $past(ratio_reg) && err_reg)
        else $error("out of range numerator accepted");

    a_err_cause: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        err_reg |-> $past(valid_reg) && $past(sw_ratio_write_in))
        else $error("error pulse without a write");

    a_no_early: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        $rose(sw_reg) |-> $past(boot_done_in) && $past(sw_ratio_write_in))
        else $error("software ratio active before boot done");

    a_active_stay: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        $past(sw_reg) |-> sw_reg)
        else $error("software ratio dropped without reset");

    a_quiet_ratio: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        valid_reg && $past(valid_reg) && !$past(sw_ratio_write_in) |-> ratio_reg == $past(ratio_reg))
        else $error("ratio changed without a write");

    // Scenario coverage
    c_rom: cover property (@(posedge clock_in) $rose(valid_reg) && sel_reg.rom_exec);
    c_par: cover property (@(posedge clock_in) $rose(valid_reg) && sel_reg.parallel8);
    c_spi: cover property (@(posedge clock_in) $rose(valid_reg) && sel_reg.spi_master);
    c_sw:  cover property (@(posedge clock_in) $rose(sw_reg));
    c_err: cover property (@(posedge clock_in) err_reg);

endmodule

`default_nettype wire

// >>> verification/boot_load_model.sv
`timescale 1ns/100ps
`default_nettype none
module boot_load_model #(parameter int LOAD_CYCLES = 8) (
    input  wire logic       clock_in,
    input  wire logic       rst_b_in,
    input  wire logic [1:0] boot_source_straps_in,
    output logic            boot_done_out
);
    int count_reg;
    // Load finishes a fixed time after reset
    always_ff @(negedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            count_reg <= 0;
        end else if (count_reg < LOAD_CYCLES) begin
            count_reg <= count_reg + 1;
        end
    end
    // Internal ROM start needs no load
    assign boot_done_out = rst_b_in && (boot_source_straps_in == 2'h3 || count_reg >= LOAD_CYCLES);
endmodule
`default_nettype wire

// >>> verification/boot_and_clock_strap_config_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module boot_and_clock_strap_config_tb_top;
    logic                              clock_in = 1'b0;
    logic                              rst_b_in = 1'b0;
    logic [1:0]                        boot_straps = 2'h0;
    logic [1:0]                        clk_straps = 2'h0;
    logic                              wr = 1'b0;
    logic [6:0]                        mult = 7'h01;
    logic [1:0]                        div_sel = 2'h0;
    logic                              boot_done, valid, byte_wide, active, err;
    logic                              err_seen = 1'b0;
    logic [1:0]                        boot_mode;
    boot_clock_strap_pkg::boot_sel_t   boot_sel;
    boot_clock_strap_pkg::clk_ratio_t  ratio;
    int                                n_fail = 0;
    int                                check_count = 0;
    always #10 clock_in = ~clock_in;
    boot_clock_strap_config i_boot_clock_strap_config (.clock_in(clock_in), .rst_b_in(rst_b_in),
        .boot_source_straps_in(boot_straps), .clock_ratio_straps_in(clk_straps), .boot_done_in(boot_done),
        .sw_ratio_write_in(wr), .sw_mult_in(mult), .sw_div_sel_in(div_sel), .straps_valid_out(valid),
        .boot_mode_out(boot_mode), .boot_sel_out(boot_sel), .byte_wide_load_out(byte_wide),
        .clk_ratio_out(ratio), .sw_ratio_active_out(active), .sw_ratio_error_out(err));
    boot_load_model i_boot_load_model (.clock_in(clock_in), .rst_b_in(rst_b_in),
        .boot_source_straps_in(boot_straps), .boot_done_out(boot_done));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish;
        if (n_fail == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic do_reset(input logic [1:0] b, input logic [1:0] c);
        rst_b_in = 1'b0;
        boot_straps = b;
        clk_straps = c;
        repeat (3) @(negedge clock_in);
        rst_b_in = 1'b1;
        @(negedge clock_in);
    endtask
    task automatic sw_write(input logic [6:0] m, input logic [1:0] d);
        wr = 1'b1;
        mult = m;
        div_sel = d;
        @(negedge clock_in);
        err_seen = err;
        wr = 1'b0;
        @(negedge clock_in);
    endtask
    task automatic strap_table;
        logic [6:0] mults [4] = '{7'h20, 7'h10, 7'h06, 7'h06};
        for (int i = 0; i < 16; i++) begin
            do_reset(i[3:2], i[1:0]);
            chk(16'(valid), 16'h1);
            chk(16'(boot_mode), 16'(i[3:2]));
            chk(16'(boot_sel), 16'(4'h8 >> i[3:2]));
            chk(16'(byte_wide), 16'(i[3:2] == 2));
            chk(16'(ratio), 16'({mults[i[1:0]], 4'h1}));
        end
    endtask
    task automatic sw_ratio_test;
        int k;
        do_reset(2'h2, 2'h1);
        boot_straps = 2'h0;
        clk_straps = 2'h0;
        sw_write(7'h05, 2'h1);
        chk(16'(err_seen), 16'h1);
        chk(16'(active), 16'h0);
        chk(16'(ratio), 16'({7'h10, 4'h1}));
        chk(16'(boot_mode), 16'h2);
        k = 0;
        while (boot_done !== 1'b1 && k < 100) begin
            @(negedge clock_in);
            k++;
        end
        if (boot_done !== 1'b1) begin
            n_fail++;
            return;
        end
        sw_write(7'h40, 2'h3);
        chk(16'(ratio), 16'({7'h40, 4'h8}));
        chk(16'(active), 16'h1);
        chk(16'(err_seen), 16'h0);
        sw_write(7'h00, 2'h0);
        chk(16'(err_seen), 16'h1);
        chk(16'(ratio), 16'({7'h40, 4'h8}));
        sw_write(7'h41, 2'h0);
        chk(16'(err_seen), 16'h1);
        chk(16'(ratio), 16'({7'h40, 4'h8}));
        for (int d = 0; d < 4; d++) begin
            sw_write(7'h01, d[1:0]);
            chk(16'(ratio), 16'({7'h01, 4'h1 << d[1:0]}));
            chk(16'(err_seen), 16'h0);
        end
    endtask
    task automatic reset_after_sw;
        do_reset(2'h3, 2'h2);
        chk(16'(ratio), 16'({7'h06, 4'h1}));
        chk(16'(active), 16'h0);
        chk(16'(boot_sel), 16'h1);
        chk(16'(byte_wide), 16'h0);
    endtask
    initial begin
        strap_table();
        sw_ratio_test();
        reset_after_sw();
        tally_and_finish();
    end
endmodule
`default_nettype wire
